// [src/timer_pkg.sv]
package timer_pkg;

  // Printed register offsets are indices; the byte address is four times the index.
  localparam logic [9:0] IDX_FLAGS = 10'h088;
  localparam logic [9:0] IDX_MODE = 10'h089;
  localparam logic [9:0] IDX_COUNT_A = 10'h090;
  localparam logic [9:0] IDX_COUNT_B = 10'h091;
  localparam logic [9:0] IDX_STATUS = 10'h092;
  localparam logic [9:0] IDX_MASK = 10'h093;
  localparam logic [11:0] ADDR_FLAGS = {IDX_FLAGS, 2'b00};
  localparam logic [11:0] ADDR_MODE = {IDX_MODE, 2'b00};
  localparam logic [11:0] ADDR_COUNT_A = {IDX_COUNT_A, 2'b00};
  localparam logic [11:0] ADDR_COUNT_B = {IDX_COUNT_B, 2'b00};
  localparam logic [11:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  localparam logic [11:0] ADDR_MASK = {IDX_MASK, 2'b00};

  // Positions in the one-hot decode vector.
  localparam int HIT_FLAGS = 0;
  localparam int HIT_MODE = 1;
  localparam int HIT_COUNT_A = 2;
  localparam int HIT_COUNT_B = 3;
  localparam int HIT_STATUS = 4;
  localparam int HIT_MASK = 5;
  localparam int HIT_COUNT = 6;

  // Fields of timer_run_and_irq_flags.
  localparam int OVERFLOW_FLAG_B = 7;
  localparam int RUN_BIT_B = 6;
  localparam int OVERFLOW_FLAG_A = 5;
  localparam int RUN_BIT_A = 4;
  localparam int EXT_REQUEST_FLAG_B = 3;
  localparam int EXT_TRIGGER_TYPE_B = 2;
  localparam int EXT_REQUEST_FLAG_A = 1;
  localparam int EXT_TRIGGER_TYPE_A = 0;

  // Fields of timer_mode_select; each timer's mode is two bits at its base.
  localparam int GATE_B = 7;
  localparam int COUNT_SRC_B = 6;
  localparam int MODE_BASE_B = 4;
  localparam int GATE_A = 3;
  localparam int COUNT_SRC_A = 2;
  localparam int MODE_BASE_A = 0;

  // Fields of the interrupt status and mask registers.
  localparam int ST_OVF_A = 0;
  localparam int ST_OVF_B = 1;
  localparam int ST_EXT_A = 2;
  localparam int ST_EXT_B = 3;

  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [3:0] EVENT_RESET = 4'h0;

  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_RELOAD8,
    MODE_SPLIT
  } count_mode_t;

endpackage

// [src/timer_core_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface timer_core_if;
  logic inc_lo;
  logic inc_hi;
  timer_pkg::count_mode_t mode;
  logic load;
  logic [15:0] load_value;
  logic [15:0] value;
  logic ovf_lo;
  logic ovf_hi;
  modport ctl (output inc_lo, inc_hi, mode, load, load_value, input value, ovf_lo, ovf_hi);
  modport core (input inc_lo, inc_hi, mode, load, load_value, output value, ovf_lo, ovf_hi);
endinterface
`default_nettype wire

// [src/pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] fall
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] prev;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  always_comb
  begin
    next_st.meta = pin;
    next_st.stable = st.meta;
    next_st.prev = st.stable;
  end

  // Pins idle high, so reset to ones to avoid a false edge after reset.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '1;
    else if (ce)
      st <= next_st;
  end

  assign level = st.stable;
  assign fall = st.prev & ~st.stable;
endmodule // pin_sync
`default_nettype wire

// [src/timer_core.sv]
`timescale 1ns/1ps
`default_nettype none
module timer_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  timer_core_if.core bus
);
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } core_state_t;

  core_state_t st;
  core_state_t next_st;

  always_comb
  begin
    next_st = st;
    bus.ovf_lo = 1'b0;
    bus.ovf_hi = 1'b0;
    case (bus.mode)
      timer_pkg::MODE_13BIT:
      begin
        if (bus.inc_lo)
        begin
          next_st.lo[4:0] = st.lo[4:0] + 5'h01;
          if (st.lo[4:0] == 5'h1f)
          begin
            next_st.hi = st.hi + 8'h01;
            bus.ovf_lo = (st.hi == 8'hff);
          end
        end
      end
      timer_pkg::MODE_16BIT:
      begin
        if (bus.inc_lo)
        begin
          next_st = core_state_t'({st.hi, st.lo} + 16'h0001);
          bus.ovf_lo = ({st.hi, st.lo} == 16'hffff);
        end
      end
      timer_pkg::MODE_RELOAD8:
      begin
        if (bus.inc_lo)
        begin
          bus.ovf_lo = (st.lo == 8'hff);
          next_st.lo = bus.ovf_lo ? st.hi : st.lo + 8'h01;
        end
      end
      timer_pkg::MODE_SPLIT:
      begin
        // The high byte runs on its own increment, steered by the other timer.
        if (bus.inc_lo)
        begin
          next_st.lo = st.lo + 8'h01;
          bus.ovf_lo = (st.lo == 8'hff);
        end
        if (bus.inc_hi)
        begin
          next_st.hi = st.hi + 8'h01;
          bus.ovf_hi = (st.hi == 8'hff);
        end
      end
      default:
      begin
        next_st = st;
      end
    endcase
    if (bus.load)
      next_st = core_state_t'(bus.load_value);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= core_state_t'(timer_pkg::COUNT_RESET);
    else if (ce)
      st <= next_st;
  end

  assign bus.value = {st.hi, st.lo};
endmodule // timer_core
`default_nettype wire

// [src/dual_timer_ext_irq_control.sv]
`timescale 1ns/1ps
`default_nettype none
module dual_timer_ext_irq_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic count_pin_a,
  input wire logic count_pin_b,
  input wire logic ext_irq_pin_a_n,
  input wire logic ext_irq_pin_b_n,
  input wire logic vector_ack_timer_a,
  input wire logic vector_ack_timer_b,
  input wire logic vector_ack_ext_a,
  input wire logic vector_ack_ext_b,
  output logic irq
);
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] mode_sel;
    logic [3:0] status;
    logic [3:0] mask;
    logic [31:0] rdata;
    logic rd_ok;
    logic err;
  } ctrl_state_t;

  ctrl_state_t st;
  ctrl_state_t next_st;

  timer_core_if ta ();
  timer_core_if tb ();

  logic [3:0] pin_level;
  logic [3:0] pin_fall;
  logic [timer_pkg::HIT_COUNT-1:0] hit;
  logic wr;
  logic en_a;
  logic en_b;
  logic tick_a;
  logic tick_b;
  logic ovf_a;
  logic ovf_b;
  logic ext_evt_a;
  logic ext_evt_b;
  logic [3:0] events;

  function automatic logic [timer_pkg::HIT_COUNT-1:0] decode(input logic [11:0] addr);
    logic [timer_pkg::HIT_COUNT-1:0] h;
    h = '0;
    h[timer_pkg::HIT_FLAGS] = (addr == timer_pkg::ADDR_FLAGS);
    h[timer_pkg::HIT_MODE] = (addr == timer_pkg::ADDR_MODE);
    h[timer_pkg::HIT_COUNT_A] = (addr == timer_pkg::ADDR_COUNT_A);
    h[timer_pkg::HIT_COUNT_B] = (addr == timer_pkg::ADDR_COUNT_B);
    h[timer_pkg::HIT_STATUS] = (addr == timer_pkg::ADDR_STATUS);
    h[timer_pkg::HIT_MASK] = (addr == timer_pkg::ADDR_MASK);
    return h;
  endfunction

  // Edge flag: vectoring clears, a new edge in the same cycle wins.
  function automatic logic ext_flag(input logic cur, input logic edge_mode,
                                    input logic fell, input logic low, input logic ack);
    logic f;
    f = cur;
    if (!edge_mode)
      f = low;
    else
    begin
      if (ack)
        f = 1'b0;
      if (fell)
        f = 1'b1;
    end
    return f;
  endfunction

  pin_sync #(
    .WIDTH(4)
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .pin({ext_irq_pin_b_n, ext_irq_pin_a_n, count_pin_b, count_pin_a}),
    .level(pin_level),
    .fall(pin_fall)
  );

  timer_core u_timer_a (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .bus(ta.core)
  );

  timer_core u_timer_b (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .bus(tb.core)
  );

  assign hit = decode(paddr);
  assign pready = psel & penable & st.rd_ok & ce;
  assign wr = pready & pwrite;
  assign prdata = st.rdata;
  assign pslverr = pready & st.err;
  assign irq = |(st.status & st.mask);

  assign ta.mode = timer_pkg::count_mode_t'(st.mode_sel[timer_pkg::MODE_BASE_A +: 2]);
  assign tb.mode = timer_pkg::count_mode_t'(st.mode_sel[timer_pkg::MODE_BASE_B +: 2]);

  // The gate pin reads high when the active-low interrupt pin is released.
  assign en_a = st.flags[timer_pkg::RUN_BIT_A]
    & (~st.mode_sel[timer_pkg::GATE_A] | pin_level[2]);
  assign en_b = st.flags[timer_pkg::RUN_BIT_B]
    & (~st.mode_sel[timer_pkg::GATE_B] | pin_level[3]);
  assign tick_a = st.mode_sel[timer_pkg::COUNT_SRC_A] ? pin_fall[0] : 1'b1;
  assign tick_b = st.mode_sel[timer_pkg::COUNT_SRC_B] ? pin_fall[1] : 1'b1;

  assign ta.inc_lo = en_a & tick_a;
  // In split mode the high byte of timer A borrows timer B's run bit and the internal clock.
  assign ta.inc_hi = (ta.mode == timer_pkg::MODE_SPLIT)
    & st.flags[timer_pkg::RUN_BIT_B];
  assign tb.inc_lo = en_b & tick_b & (tb.mode != timer_pkg::MODE_SPLIT);
  assign tb.inc_hi = 1'b0;

  assign ta.load = wr & hit[timer_pkg::HIT_COUNT_A];
  assign tb.load = wr & hit[timer_pkg::HIT_COUNT_B];
  assign ta.load_value = pwdata[15:0];
  assign tb.load_value = pwdata[15:0];

  assign ovf_a = ta.ovf_lo;
  assign ovf_b = tb.ovf_lo | ta.ovf_hi;

  // Trigger type one means falling edge, zero means low level.
  assign ext_evt_a = st.flags[timer_pkg::EXT_TRIGGER_TYPE_A]
    ? pin_fall[2] : ~pin_level[2];
  assign ext_evt_b = st.flags[timer_pkg::EXT_TRIGGER_TYPE_B]
    ? pin_fall[3] : ~pin_level[3];

  always_comb
  begin
    events = '0;
    events[timer_pkg::ST_OVF_A] = ovf_a;
    events[timer_pkg::ST_OVF_B] = ovf_b;
    events[timer_pkg::ST_EXT_A] = ext_evt_a;
    events[timer_pkg::ST_EXT_B] = ext_evt_b;
  end

  always_comb
  begin
    next_st = st;

    // Read data is captured in the setup cycle so prdata comes from a flop.
    if (psel && !penable)
    begin
      next_st.rd_ok = 1'b1;
      next_st.err = ~|hit;
      next_st.rdata = '0;
      case (1'b1)
        hit[timer_pkg::HIT_FLAGS]:
          next_st.rdata[7:0] = st.flags;
        hit[timer_pkg::HIT_MODE]:
          next_st.rdata[7:0] = st.mode_sel;
        hit[timer_pkg::HIT_COUNT_A]:
          next_st.rdata[15:0] = ta.value;
        hit[timer_pkg::HIT_COUNT_B]:
          next_st.rdata[15:0] = tb.value;
        hit[timer_pkg::HIT_STATUS]:
          next_st.rdata[3:0] = st.status;
        hit[timer_pkg::HIT_MASK]:
          next_st.rdata[3:0] = st.mask;
        default:
          next_st.rdata = '0;
      endcase
    end
    if (pready)
      next_st.rd_ok = 1'b0;

    if (wr && hit[timer_pkg::HIT_FLAGS])
      next_st.flags = pwdata[7:0];
    if (wr && hit[timer_pkg::HIT_MODE])
      next_st.mode_sel = pwdata[7:0];
    if (wr && hit[timer_pkg::HIT_MASK])
      next_st.mask = pwdata[3:0];

    // Hardware updates follow the software write so that a hardware set wins over both the write and a vectoring clear.
    if (vector_ack_timer_b)
      next_st.flags[timer_pkg::OVERFLOW_FLAG_B] = 1'b0;
    if (ovf_b)
      next_st.flags[timer_pkg::OVERFLOW_FLAG_B] = 1'b1;
    if (vector_ack_timer_a)
      next_st.flags[timer_pkg::OVERFLOW_FLAG_A] = 1'b0;
    if (ovf_a)
      next_st.flags[timer_pkg::OVERFLOW_FLAG_A] = 1'b1;

    next_st.flags[timer_pkg::EXT_REQUEST_FLAG_B] = ext_flag(
      next_st.flags[timer_pkg::EXT_REQUEST_FLAG_B],
      st.flags[timer_pkg::EXT_TRIGGER_TYPE_B],
      pin_fall[3], ~pin_level[3], vector_ack_ext_b);
    next_st.flags[timer_pkg::EXT_REQUEST_FLAG_A] = ext_flag(
      next_st.flags[timer_pkg::EXT_REQUEST_FLAG_A],
      st.flags[timer_pkg::EXT_TRIGGER_TYPE_A],
      pin_fall[2], ~pin_level[2], vector_ack_ext_a);

    if (wr && hit[timer_pkg::HIT_STATUS])
      next_st.status = st.status & ~pwdata[3:0];
    next_st.status = next_st.status | events;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st.flags <= timer_pkg::FLAGS_RESET;
      st.mode_sel <= timer_pkg::MODE_RESET;
      st.status <= timer_pkg::EVENT_RESET;
      st.mask <= timer_pkg::EVENT_RESET;
      st.rdata <= '0;
      st.rd_ok <= 1'b0;
      st.err <= 1'b0;
    end
    else if (ce)
      st <= next_st;
  end

  default clocking cb_main @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable && ce;
  endsequence

  sequence s_access;
    psel && penable && ce;
  endsequence

  a_apb_ready_access: assert property (s_setup ##1 s_access |-> pready)
    else $error("APB access phase not answered at once");

  a_ovf_b_set: assert property (ce && ovf_b |=> st.flags[timer_pkg::OVERFLOW_FLAG_B])
    else $error("Timer B overflow did not set its flag");

  a_ovf_a_clear: assert property (ce && vector_ack_timer_a && !ovf_a
    && !(wr && hit[timer_pkg::HIT_FLAGS])
    |=> !st.flags[timer_pkg::OVERFLOW_FLAG_A])
    else $error("Timer A flag not cleared by vectoring");

  a_run_off_hold: assert property (ce && !st.flags[timer_pkg::RUN_BIT_A]
    && ta.mode != timer_pkg::MODE_SPLIT && !ta.load |=> $stable(ta.value))
    else $error("Timer A moved while its run bit was clear");

  a_ext_edge_b: assert property (ce && st.flags[timer_pkg::EXT_TRIGGER_TYPE_B] && pin_fall[3]
    |=> st.flags[timer_pkg::EXT_REQUEST_FLAG_B])
    else $error("Edge on pin B did not raise its request flag");

  a_ext_ack_a: assert property (ce && st.flags[timer_pkg::EXT_TRIGGER_TYPE_A] && vector_ack_ext_a
    && !pin_fall[2] && !(wr && hit[timer_pkg::HIT_FLAGS])
    |=> !st.flags[timer_pkg::EXT_REQUEST_FLAG_A])
    else $error("Edge request A not cleared by vectoring");

  a_ext_level_a: assert property (ce && !st.flags[timer_pkg::EXT_TRIGGER_TYPE_A]
    |=> st.flags[timer_pkg::EXT_REQUEST_FLAG_A] == !$past(pin_level[2]))
    else $error("Level request A does not follow the pin");

  a_gate_b_hold: assert property (ce && st.mode_sel[timer_pkg::GATE_B] && !pin_level[3]
    && !tb.load |=> $stable(tb.value))
    else $error("Gated timer B counted with its pin low");

  a_count_16_a: assert property (ce && ta.mode == timer_pkg::MODE_16BIT && en_a
    && !st.mode_sel[timer_pkg::COUNT_SRC_A] && !ta.load
    |=> ta.value == 16'($past(ta.value) + 16'h0001))
    else $error("Timer A did not step in 16-bit mode");

  a_reload_a: assert property (ce && ta.mode == timer_pkg::MODE_RELOAD8 && ta.inc_lo
    && ta.value[7:0] == 8'hff && !ta.load |=> ta.value[7:0] == $past(ta.value[15:8]))
    else $error("Timer A low byte not reloaded");

  a_split_b_stop: assert property (ce && tb.mode == timer_pkg::MODE_SPLIT && !tb.load
    |=> $stable(tb.value))
    else $error("Timer B ran in split mode");

  a_status_sticky: assert property (ce && st.status[timer_pkg::ST_OVF_A]
    && !(wr && hit[timer_pkg::HIT_STATUS]) |=> st.status[timer_pkg::ST_OVF_A])
    else $error("Status bit lost without a clear");

endmodule // dual_timer_ext_irq_control
`default_nettype wire

// [testbench/pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_model (
  input wire logic pclk,
  output logic count_pin_a,
  output logic count_pin_b,
  output logic ext_irq_pin_a_n,
  output logic ext_irq_pin_b_n
);
  // Pins rest high, as with board pull-ups, so no false edge is seen after reset.
  initial
  begin
    count_pin_a = 1'b1;
    count_pin_b = 1'b1;
    ext_irq_pin_a_n = 1'b1;
    ext_irq_pin_b_n = 1'b1;
  end

  // Each level lasts two clocks, so the synchroniser sees every edge.
  task automatic pulse(input bit b, input int n);
    repeat (n)
    begin
      @(posedge pclk);
      if (b) count_pin_b <= 1'b0; else count_pin_a <= 1'b0;
      repeat (2) @(posedge pclk);
      if (b) count_pin_b <= 1'b1; else count_pin_a <= 1'b1;
      @(posedge pclk);
    end
  endtask

  task automatic set_irq(input bit b, input logic v);
    @(posedge pclk);
    if (b) ext_irq_pin_b_n <= v; else ext_irq_pin_a_n <= v;
  endtask
endmodule // pin_model
`default_nettype wire

// [testbench/test_dual_timer_ext_irq_control.sv]
`timescale 1ns/1ps
`default_nettype none
module test_dual_timer_ext_irq_control;
  localparam logic [11:0] addr_flags = timer_pkg::ADDR_FLAGS;
  localparam logic [11:0] addr_mode = timer_pkg::ADDR_MODE;
  localparam logic [11:0] addr_ca = timer_pkg::ADDR_COUNT_A;
  localparam logic [11:0] addr_cb = timer_pkg::ADDR_COUNT_B;
  localparam logic [11:0] addr_st = timer_pkg::ADDR_STATUS;
  localparam logic [11:0] addr_mask = timer_pkg::ADDR_MASK;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, last_err;
  logic count_pin_a, count_pin_b, ext_irq_pin_a_n, ext_irq_pin_b_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, v;
  logic [3:0] acks;
  int error_cnt = 0;
  int compares = 0;

  dual_timer_ext_irq_control dut (
    .pclk, .presetn, .ce(1'b1), .paddr, .psel, .penable, .pwrite, .pwdata,
    .pready, .prdata, .pslverr, .count_pin_a, .count_pin_b,
    .ext_irq_pin_a_n, .ext_irq_pin_b_n,
    .vector_ack_timer_a(acks[0]), .vector_ack_timer_b(acks[1]),
    .vector_ack_ext_a(acks[2]), .vector_ack_ext_b(acks[3]), .irq
  );

  pin_model pins (
    .pclk, .count_pin_a, .count_pin_b, .ext_irq_pin_a_n, .ext_irq_pin_b_n
  );

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // The request is held until pready is sampled high at a rising edge, then released.
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] r);
    int n;
    n = 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    last_err = pslverr;
    r = prdata;
    if (n == 20)
    begin
      chk("pready", 32'h1, 32'h0);
      end_of_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(a, 1'b1, d, r);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(a, 1'b0, 32'h0, q);
  endtask

  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    chk("irq", 32'h1, {31'h0, irq});
    if (n == lim) end_of_test();
  endtask

  task automatic ack(input int i);
    @(posedge pclk);
    acks[i] <= 1'b1;
    @(posedge pclk);
    acks <= 4'h0;
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    acks = 4'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(addr_flags);
    chk("flags reset", 32'h0, q);
    rd(addr_mode);
    chk("mode reset", 32'h0, q);
    rd(12'h000);
    chk("unmapped err", 32'h1, {31'h0, last_err});
    $display("test reset done");

    wr(addr_mode, 32'h01);
    wr(addr_mask, 32'h1);
    wr(addr_ca, 32'hfffe);
    wr(addr_flags, 32'h10);
    wait_irq(20);
    rd(addr_flags);
    chk("ovf a set", 32'h30, q);
    wr(addr_flags, 32'h20);
    rd(addr_ca);
    v = q;
    repeat (5) @(posedge pclk);
    rd(addr_ca);
    chk("count held", v, q);
    ack(0);
    rd(addr_flags);
    chk("ovf a cleared", 32'h0, q);
    rd(addr_st);
    chk("status", 32'h1, q);
    wr(addr_st, 32'h1);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(addr_flags, 32'h80);
    rd(addr_flags);
    chk("ovf b by sw", 32'h80, q);
    wr(addr_flags, 32'h0);
    $display("test overflow a done");

    // A 16-bit count from ff1e would need hundreds of clocks; 13 bits need two.
    wr(addr_mode, 32'h00);
    wr(addr_ca, 32'hff1e);
    wr(addr_flags, 32'h10);
    wait_irq(20);
    wr(addr_flags, 32'h0);
    wr(addr_st, 32'hf);
    $display("test mode 13 bit done");

    wr(addr_mode, 32'h0d);
    wr(addr_ca, 32'h0);
    wr(addr_flags, 32'h10);
    pins.set_irq(1'b0, 1'b0);
    pins.pulse(1'b0, 3);
    rd(addr_ca);
    chk("gated count", 32'h0, q);
    rd(addr_flags);
    chk("level req a", 32'h12, q);
    pins.set_irq(1'b0, 1'b1);
    repeat (6) @(posedge pclk);
    rd(addr_flags);
    chk("level req gone", 32'h10, q);
    pins.pulse(1'b0, 3);
    repeat (4) @(posedge pclk);
    rd(addr_ca);
    chk("pin count", 32'h3, q);
    wr(addr_flags, 32'h0);
    wr(addr_st, 32'hf);
    $display("test count pin done");

    wr(addr_mode, 32'h20);
    wr(addr_mask, 32'h2);
    wr(addr_cb, 32'h80fe);
    wr(addr_flags, 32'h40);
    wait_irq(20);
    rd(addr_flags);
    chk("ovf b set", 32'hc0, q);
    wr(addr_flags, 32'h80);
    rd(addr_flags);
    chk("ovf b kept", 32'h80, q);
    rd(addr_cb);
    chk("reload", 32'h8080, q & 32'hff80);
    ack(1);
    rd(addr_flags);
    chk("ovf b cleared", 32'h0, q);
    wr(addr_st, 32'hf);
    $display("test reload b done");

    wr(addr_mask, 32'h8);
    wr(addr_flags, 32'h04);
    pins.set_irq(1'b1, 1'b0);
    repeat (3) @(posedge pclk);
    pins.set_irq(1'b1, 1'b1);
    wait_irq(20);
    rd(addr_flags);
    chk("edge req b", 32'h0c, q);
    ack(3);
    rd(addr_flags);
    chk("edge req b ack", 32'h04, q);
    wr(addr_st, 32'hf);
    $display("test edge b done");

    wr(addr_mode, 32'h30);
    wr(addr_cb, 32'h1234);
    wr(addr_flags, 32'h40);
    repeat (8) @(posedge pclk);
    rd(addr_cb);
    chk("b stopped", 32'h1234, q);
    wr(addr_flags, 32'h0);
    wr(addr_mode, 32'h03);
    wr(addr_ca, 32'h0);
    wr(addr_flags, 32'h40);
    repeat (8) @(posedge pclk);
    wr(addr_flags, 32'h0);
    rd(addr_ca);
    chk("split lo held", 32'h0, q & 32'hff);
    chk("split hi runs", 32'h1, {31'h0, q[15:8] != 8'h00});
    $display("test split mode done");
    end_of_test();
  end
endmodule // test_dual_timer_ext_irq_control
`default_nettype wire
